// ---- csw_pkg.sv ----
package csw_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int STAMP_W    = 64;
  localparam int STAMP_FIX_W = 56;
  localparam int STAMP_USR_W = 8;
  localparam int ID_W       = 32;
  localparam int NPORT      = 3;
  localparam int CMD_W      = 2;
  localparam int SPACE_W    = 5;

  // ----------------------------------------------------------------
  // Reset values and defaults
  // ----------------------------------------------------------------
  localparam logic [STAMP_USR_W-1:0] STAMP_USR_DEF = 8'h00;
  localparam logic [ID_W-1:0]        USER_VER_DEF  = 32'h0000_0000;
  localparam logic [ID_W-1:0]        WORD_ZERO     = 32'h0000_0000;
  localparam logic [STAMP_W-1:0]     STAMP_ZERO    = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------
  // Read targets and commands
  // ----------------------------------------------------------------
  localparam logic [CMD_W-1:0] TGT_SRAM  = 2'h0;
  localparam logic [CMD_W-1:0] TGT_STORE = 2'h1;
  localparam logic [CMD_W-1:0] CMD_ERASE = 2'h0;
  localparam logic [CMD_W-1:0] CMD_PROG  = 2'h1;

  // ----------------------------------------------------------------
  // Wake-up spacing in configuration clock cycles
  // ----------------------------------------------------------------
  localparam logic [SPACE_W-1:0] WAKE_GAP = 5'h01;
  localparam logic [SPACE_W-1:0] GAP_ZERO = 5'h00;

  // Wake-up states
  typedef enum logic [4:0] {
    ST_CONFIG  = 5'b00001,
    ST_RST_REL = 5'b00010,
    ST_WR_REL  = 5'b00100,
    ST_OE_REL  = 5'b01000,
    ST_USER    = 5'b10000
  } csw_wake_e;
endpackage : csw_pkg

// ---- csw_sync_if.sv ----
`timescale 1ns/1ps
// Level signals that cross into the clock domain and their synced copies
interface csw_sync_if;
  import csw_pkg::*;
  logic [NPORT-1:0] raw;
  logic [NPORT-1:0] synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface : csw_sync_if

// ---- csw_sync.sv ----
`timescale 1ns/1ps
module csw_sync
(
  // Clock and reset
  input  wire logic I_CLK,
  input  wire logic I_SYS_RST,
  // Signals
  csw_sync_if.dst   bus
);
  import csw_pkg::*;

  logic [NPORT-1:0] s1_q;
  logic [NPORT-1:0] s2_q;
  logic [NPORT-1:0] s3_q;
  logic [NPORT-1:0] out_q;

  // Three-stage chain; output moves when stages two and three agree
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end
    else
    begin
      s1_q <= bus.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NPORT; i++)
      begin
        if (s2_q[i] == s3_q[i])
        begin
          out_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign bus.synced = out_q;
endmodule : csw_sync

// ---- csw_top.sv ----
`timescale 1ns/1ps
// What this block does
// - Fixed 56-bit factory part of die stamp
// - Upper stamp byte from feature row
// - Override identity word when option on
// - Identity word readable on every port
// - Locked memory refuses all readback
// - Each lock guards its own target only
// - Store erase clears lock if I_NONVOLATILE_READBACK_LOCK low, reprogram allowed
// - Fuse rejects SRAM erase and program
// - Wake-up starts when done flag set on last in chain, no error
// - Core reset low during configuration
// - Write block low before wake-up
// - Output enable low blocks outputs only
// - Inputs honoured after done flag
// - Completion pin high only without errors
// - User version word, default zero
module csw_top
  import csw_pkg::*;
#(
  parameter logic [csw_pkg::STAMP_FIX_W-1:0] FACTORY_STAMP = 56'h00_0000_0000_0000, // arbitrary
  parameter logic [csw_pkg::ID_W-1:0]        FACTORY_ID    = 32'h0000_0001          // arbitrary
)
(
  // Clock and reset
  input  wire logic                          I_CLK,
  input  wire logic                          I_SYS_RST,
  // Feature row contents
  input  wire logic [csw_pkg::STAMP_USR_W-1:0] I_STAMP_USER,
  input  wire logic                          I_CUSTOM_IDENTITY_ENABLE,
  input  wire logic [csw_pkg::ID_W-1:0]      I_OVERRIDE_IDENTITY_WORD,
  input  wire logic [csw_pkg::ID_W-1:0]      I_USER_VERSION_WORD,
  input  wire logic                          I_USER_VERSION_VALID,
  input  wire logic                          I_SRAM_READBACK_LOCK,
  input  wire logic                          I_NONVOLATILE_READBACK_LOCK,
  input  wire logic                          I_SRAM_ERASE_PROGRAM_FUSE,
  // Loader status
  input  wire logic                          I_LOAD_DONE,
  input  wire logic                          I_LOAD_ERROR,
  input  wire logic                          I_LAST_IN_CHAIN,
  // Identity reads, one request line per configuration port
  input  wire logic [csw_pkg::NPORT-1:0]     I_ID_READ_REQ,
  output logic [csw_pkg::ID_W-1:0]           O_ID_WORD,
  output logic [csw_pkg::STAMP_W-1:0]        O_UNIQUE_DIE_STAMP,
  output logic [csw_pkg::ID_W-1:0]           O_USER_VERSION_WORD,
  output logic                               O_ID_VALID,
  // Readback requests
  input  wire logic                          I_RDBK_REQ,
  input  wire logic [csw_pkg::CMD_W-1:0]     I_RDBK_TARGET,
  output logic                               O_RDBK_GRANT,
  output logic                               O_RDBK_REFUSE,
  // Erase and program commands
  input  wire logic                          I_CMD_REQ,
  input  wire logic [csw_pkg::CMD_W-1:0]     I_CMD_TARGET,
  input  wire logic [csw_pkg::CMD_W-1:0]     I_CMD_OP,
  output logic                               O_CMD_ACCEPT,
  output logic                               O_CMD_REJECT,
  output logic                               O_STORE_LOCK_CLEAR,
  // Wake-up controls
  output logic                               O_CORE_GLOBAL_RESET_N,
  output logic                               O_GLOBAL_WRITE_BLOCK_N,
  output logic                               O_GLOBAL_OUTPUT_ENABLE_N,
  output logic                               O_INPUT_ACCEPT,
  output logic                               O_CONFIG_COMPLETE_PIN
);
  import csw_pkg::*;

  // ----------------------------------------------------------------
  // Synchroniser for port requests
  // ----------------------------------------------------------------
  csw_sync_if sync_bus ();
  assign sync_bus.raw = I_ID_READ_REQ;

  csw_sync u_sync
  (
    .I_CLK     (I_CLK),
    .I_SYS_RST (I_SYS_RST),
    .bus       (sync_bus)
  );

  logic [NPORT-1:0] req_prev_q;
  logic [ID_W-1:0]  id_word_q;
  logic [STAMP_W-1:0] stamp_q;
  logic [ID_W-1:0]  user_ver_q;
  logic             id_valid_q;
  logic             store_lock_q;
  logic             rdbk_grant_q;
  logic             rdbk_refuse_q;
  logic             cmd_accept_q;
  logic             cmd_reject_q;
  logic             lock_clear_q;
  logic             err_q;
  csw_wake_e        state_q;
  csw_wake_e        state_d;
  logic [SPACE_W-1:0] gap_q;
  logic             rst_n_q;
  logic             wr_n_q;
  logic             oe_n_q;
  logic             inp_q;
  logic             config_complete_pin_q;
  logic             any_rise;

  // ----------------------------------------------------------------
  // Identity words
  // ----------------------------------------------------------------
  // Any port request, rising edge of synced level
  assign any_rise = |(sync_bus.synced & ~req_prev_q);

  // Identity, stamp and version capture on read
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      req_prev_q <= '0;
      id_word_q  <= WORD_ZERO;
      stamp_q    <= STAMP_ZERO;
      user_ver_q <= USER_VER_DEF;
      id_valid_q <= 1'b0;
    end
    else
    begin
      req_prev_q <= sync_bus.synced;
      id_valid_q <= any_rise;
      if (any_rise)
      begin
        id_word_q  <= I_CUSTOM_IDENTITY_ENABLE ? I_OVERRIDE_IDENTITY_WORD
                                               : FACTORY_ID;
        stamp_q    <= {I_STAMP_USER, FACTORY_STAMP};
        user_ver_q <= I_USER_VERSION_VALID ? I_USER_VERSION_WORD
                                           : USER_VER_DEF;
      end
    end
  end

  // ----------------------------------------------------------------
  // Readback locks
  // ----------------------------------------------------------------
  // Store lock held until the store is erased with I_NONVOLATILE_READBACK_LOCK low
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      store_lock_q <= 1'b0;
    end
    else if (I_NONVOLATILE_READBACK_LOCK && !lock_clear_q)
    begin
      store_lock_q <= 1'b1;
    end
    else if (I_CMD_REQ && I_CMD_TARGET == TGT_STORE && I_CMD_OP == CMD_ERASE)
    begin
      store_lock_q <= 1'b0;
    end
  end

  // Grant or refuse readback per target
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      rdbk_grant_q  <= 1'b0;
      rdbk_refuse_q <= 1'b0;
    end
    else
    begin
      rdbk_grant_q  <= 1'b0;
      rdbk_refuse_q <= 1'b0;
      if (I_RDBK_REQ)
      begin
        if ((I_RDBK_TARGET == TGT_SRAM && I_SRAM_READBACK_LOCK) ||
            (I_RDBK_TARGET == TGT_STORE && store_lock_q))
        begin
          rdbk_refuse_q <= 1'b1;
        end
        else
        begin
          rdbk_grant_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Erase and program commands
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      cmd_accept_q <= 1'b0;
      cmd_reject_q <= 1'b0;
      lock_clear_q <= 1'b0;
    end
    else
    begin
      cmd_accept_q <= 1'b0;
      cmd_reject_q <= 1'b0;
      lock_clear_q <= 1'b0;
      if (I_CMD_REQ)
      begin
        if (I_CMD_TARGET == TGT_SRAM && I_SRAM_ERASE_PROGRAM_FUSE)
        begin
          cmd_reject_q <= 1'b1;
        end
        else
        begin
          cmd_accept_q <= 1'b1;
          lock_clear_q <= (I_CMD_TARGET == TGT_STORE) && (I_CMD_OP == CMD_ERASE);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Wake-up sequence
  // ----------------------------------------------------------------
  // Next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_CONFIG:  if (I_LOAD_DONE && I_LAST_IN_CHAIN && !I_LOAD_ERROR) state_d = ST_RST_REL;
      ST_RST_REL: if (gap_q == GAP_ZERO) state_d = ST_WR_REL;
      ST_WR_REL:  if (gap_q == GAP_ZERO) state_d = ST_OE_REL;
      ST_OE_REL:  state_d = ST_USER;
      ST_USER:    state_d = ST_USER;
      default:    state_d = ST_CONFIG;
    endcase
  end

  // State and spacing counter
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state_q <= ST_CONFIG;
      gap_q   <= WAKE_GAP;
    end
    else
    begin
      state_q <= state_d;
      if (state_d != state_q)
      begin
        gap_q <= WAKE_GAP;
      end
      else if (gap_q != GAP_ZERO)
      begin
        gap_q <= gap_q - 1'b1;
      end
    end
  end

  // Sticky load error
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      err_q <= 1'b0;
    end
    else if (I_LOAD_ERROR)
    begin
      err_q <= 1'b1;
    end
  end

  // Wake-up control outputs
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      rst_n_q <= 1'b0;
      wr_n_q  <= 1'b0;
      oe_n_q  <= 1'b0;
      inp_q   <= 1'b0;
      config_complete_pin_q <= 1'b0;
    end
    else
    begin
      rst_n_q <= state_q != ST_CONFIG;
      wr_n_q  <= (state_q == ST_WR_REL) || (state_q == ST_OE_REL) ||
                 (state_q == ST_USER);
      oe_n_q  <= (state_q == ST_OE_REL) || (state_q == ST_USER);
      inp_q   <= I_LOAD_DONE;
      config_complete_pin_q <= (state_q == ST_USER) && !err_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_ID_WORD                = id_word_q;
  assign O_UNIQUE_DIE_STAMP       = stamp_q;
  assign O_USER_VERSION_WORD      = user_ver_q;
  assign O_ID_VALID               = id_valid_q;
  assign O_RDBK_GRANT             = rdbk_grant_q;
  assign O_RDBK_REFUSE            = rdbk_refuse_q;
  assign O_CMD_ACCEPT             = cmd_accept_q;
  assign O_CMD_REJECT             = cmd_reject_q;
  assign O_STORE_LOCK_CLEAR       = lock_clear_q;
  assign O_CORE_GLOBAL_RESET_N    = rst_n_q;
  assign O_GLOBAL_WRITE_BLOCK_N   = wr_n_q;
  assign O_GLOBAL_OUTPUT_ENABLE_N = oe_n_q;
  assign O_INPUT_ACCEPT           = inp_q;
  assign O_CONFIG_COMPLETE_PIN    = config_complete_pin_q;
endmodule : csw_top

// ---- csw_chk.sv ----
`timescale 1ns/1ps
module csw_chk
  import csw_pkg::*;
#(
  parameter logic [csw_pkg::STAMP_FIX_W-1:0] FACTORY_STAMP = '0,
  parameter logic [csw_pkg::ID_W-1:0]        FACTORY_ID    = '0
)
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // Watched inputs
  input wire logic [csw_pkg::STAMP_USR_W-1:0] I_STAMP_USER,
  input wire logic I_CUSTOM_IDENTITY_ENABLE,
  input wire logic [csw_pkg::ID_W-1:0] I_OVERRIDE_IDENTITY_WORD,
  input wire logic [csw_pkg::ID_W-1:0] I_USER_VERSION_WORD,
  input wire logic I_USER_VERSION_VALID,
  input wire logic I_SRAM_READBACK_LOCK,
  input wire logic I_SRAM_ERASE_PROGRAM_FUSE,
  input wire logic I_LOAD_DONE,
  input wire logic I_LOAD_ERROR,
  input wire logic I_RDBK_REQ,
  input wire logic [csw_pkg::CMD_W-1:0] I_RDBK_TARGET,
  input wire logic I_CMD_REQ,
  input wire logic [csw_pkg::CMD_W-1:0] I_CMD_TARGET,
  input wire logic [csw_pkg::CMD_W-1:0] I_CMD_OP,
  // Watched outputs
  input wire logic [csw_pkg::ID_W-1:0] O_ID_WORD,
  input wire logic [csw_pkg::STAMP_W-1:0] O_UNIQUE_DIE_STAMP,
  input wire logic [csw_pkg::ID_W-1:0] O_USER_VERSION_WORD,
  input wire logic O_ID_VALID,
  input wire logic O_RDBK_GRANT,
  input wire logic O_RDBK_REFUSE,
  input wire logic O_CMD_ACCEPT,
  input wire logic O_CMD_REJECT,
  input wire logic O_STORE_LOCK_CLEAR,
  input wire logic O_CORE_GLOBAL_RESET_N,
  input wire logic O_GLOBAL_WRITE_BLOCK_N,
  input wire logic O_GLOBAL_OUTPUT_ENABLE_N,
  input wire logic O_INPUT_ACCEPT,
  input wire logic O_CONFIG_COMPLETE_PIN
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // Captured words follow the inputs seen at the capture edge
  a_id_word_sel: assert property (O_ID_VALID |->
    O_ID_WORD == ($past(I_CUSTOM_IDENTITY_ENABLE) ? $past(I_OVERRIDE_IDENTITY_WORD) : FACTORY_ID))
    else $error("identity word wrong");
  a_die_stamp_cat: assert property (O_ID_VALID |->
    O_UNIQUE_DIE_STAMP == {$past(I_STAMP_USER), FACTORY_STAMP})
    else $error("die stamp wrong");
  a_version_word: assert property (O_ID_VALID |-> O_USER_VERSION_WORD ==
    ($past(I_USER_VERSION_VALID) ? $past(I_USER_VERSION_WORD) : USER_VER_DEF))
    else $error("version word wrong");
  a_sram_rdbk_lock: assert property (I_RDBK_REQ && I_RDBK_TARGET == TGT_SRAM &&
    I_SRAM_READBACK_LOCK |=> O_RDBK_REFUSE && !O_RDBK_GRANT)
    else $error("locked readback served");
  a_sram_rdbk_open: assert property (I_RDBK_REQ && I_RDBK_TARGET == TGT_SRAM &&
    !I_SRAM_READBACK_LOCK |=> O_RDBK_GRANT && !O_RDBK_REFUSE)
    else $error("open readback refused");
  a_fuse_rejects: assert property (I_CMD_REQ && I_CMD_TARGET == TGT_SRAM &&
    I_SRAM_ERASE_PROGRAM_FUSE |=> O_CMD_REJECT && !O_CMD_ACCEPT)
    else $error("fused command taken");
  a_store_erase_clr: assert property (I_CMD_REQ && I_CMD_TARGET == TGT_STORE &&
    I_CMD_OP == CMD_ERASE |=> O_CMD_ACCEPT && O_STORE_LOCK_CLEAR)
    else $error("store erase no clear");
  // Core reset rises one cycle after the state leaves configuration
  a_reset_rel_cause: assert property ($rose(O_CORE_GLOBAL_RESET_N) |->
    $past(I_LOAD_DONE, 2) && !$past(I_LOAD_ERROR, 2))
    else $error("core reset released early");
  a_write_blk_order: assert property ($rose(O_CORE_GLOBAL_RESET_N) |->
    !O_GLOBAL_WRITE_BLOCK_N ##[1:4] O_GLOBAL_WRITE_BLOCK_N)
    else $error("write block order");
  a_oe_after_wb: assert property ($rose(O_GLOBAL_OUTPUT_ENABLE_N) |->
    O_GLOBAL_WRITE_BLOCK_N && $past(O_GLOBAL_WRITE_BLOCK_N))
    else $error("output enable order");
  a_input_after_done: assert property ($rose(I_LOAD_DONE) |=> O_INPUT_ACCEPT)
    else $error("inputs not honoured");
  a_done_pin_clean: assert property ($rose(O_CONFIG_COMPLETE_PIN) |->
    O_GLOBAL_OUTPUT_ENABLE_N && !$past(I_LOAD_ERROR))
    else $error("completion pin early");
  // Main scenarios reached
  c_refuse: cover property (O_RDBK_REFUSE);
  c_reject: cover property (O_CMD_REJECT);
  c_woken: cover property ($rose(O_CONFIG_COMPLETE_PIN));
endmodule : csw_chk

bind csw_top csw_chk #(.FACTORY_STAMP(FACTORY_STAMP), .FACTORY_ID(FACTORY_ID)) u_chk (.*);

// ---- csw_host.sv ----
`timescale 1ns/1ps
module csw_host
(
  // Clock
  input  wire logic                      i_clk,
  // Requests
  output logic [csw_pkg::NPORT-1:0]      o_id_req,
  output logic                           o_rdbk_req,
  output logic [csw_pkg::CMD_W-1:0]      o_rdbk_tgt,
  output logic                           o_cmd_req,
  output logic [csw_pkg::CMD_W-1:0]      o_cmd_tgt,
  output logic [csw_pkg::CMD_W-1:0]      o_cmd_op,
  // Answers
  input  wire logic                      i_id_valid,
  input  wire logic                      i_grant,
  input  wire logic                      i_refuse,
  input  wire logic                      i_accept,
  input  wire logic                      i_reject
);
  import csw_pkg::*;
  // Quiet until asked
  initial
  begin
    o_id_req = '0;
    o_rdbk_req = 1'b0;
    o_rdbk_tgt = TGT_STORE;
    o_cmd_req = 1'b0;
    o_cmd_tgt = TGT_STORE;
    o_cmd_op = CMD_PROG;
  end
  task automatic step;
    @(posedge i_clk);
    #1;
  endtask : step
  // Level request on one port, held until words arrive
  task automatic read_id(input int p, output logic v);
    o_id_req[p] = 1'b1;
    for (int i = 0; i < 20 && i_id_valid !== 1'b1; i++) step();
    v = i_id_valid;
    o_id_req[p] = 1'b0;
    repeat (8) step();
  endtask : read_id
  // One-cycle readback request; released target shows garbage
  task automatic rdbk(input logic [CMD_W-1:0] t, output logic g, output logic r);
    o_rdbk_tgt = t;
    o_rdbk_req = 1'b1;
    step();
    o_rdbk_req = 1'b0;
    o_rdbk_tgt = ~t;
    g = i_grant;
    r = i_refuse;
    step();
  endtask : rdbk
  // One-cycle erase or program command
  task automatic cmd(input logic [CMD_W-1:0] t, op, output logic a, output logic r);
    o_cmd_tgt = t;
    o_cmd_op = op;
    o_cmd_req = 1'b1;
    step();
    o_cmd_req = 1'b0;
    o_cmd_tgt = ~t;
    o_cmd_op = ~op;
    a = i_accept;
    r = i_reject;
    step();
  endtask : cmd
endmodule : csw_host

// ---- csw_top_tb.sv ----
`timescale 1ns/1ps
module csw_top_tb;
  import csw_pkg::*;
  localparam logic [STAMP_FIX_W-1:0] FSTAMP = 56'h12_3456_789A_BCDE; // Arbitrary
  localparam logic [ID_W-1:0]        FID    = 32'h0A5C_0001;         // Arbitrary
  logic I_CLK = 1'b0, I_SYS_RST = 1'b1, I_CUSTOM_IDENTITY_ENABLE = 1'b0;
  logic I_USER_VERSION_VALID = 1'b0, I_SRAM_READBACK_LOCK = 1'b0;
  logic I_NONVOLATILE_READBACK_LOCK = 1'b0;
  logic I_SRAM_ERASE_PROGRAM_FUSE = 1'b0, I_LOAD_DONE = 1'b0, I_LOAD_ERROR = 1'b0;
  logic I_LAST_IN_CHAIN = 1'b1;
  logic [STAMP_USR_W-1:0] I_STAMP_USER = 8'h00;
  logic [ID_W-1:0] I_OVERRIDE_IDENTITY_WORD = 32'hC0DE_5A17, I_USER_VERSION_WORD = 32'h1234_5678;
  logic [ID_W-1:0] O_ID_WORD, O_USER_VERSION_WORD;
  logic [STAMP_W-1:0] O_UNIQUE_DIE_STAMP;
  logic [NPORT-1:0] I_ID_READ_REQ;
  logic [CMD_W-1:0] I_RDBK_TARGET, I_CMD_TARGET, I_CMD_OP;
  logic I_RDBK_REQ, I_CMD_REQ, O_ID_VALID, O_RDBK_GRANT, O_RDBK_REFUSE, O_CMD_ACCEPT, O_CMD_REJECT;
  logic O_STORE_LOCK_CLEAR, O_CORE_GLOBAL_RESET_N, O_GLOBAL_WRITE_BLOCK_N;
  logic O_GLOBAL_OUTPUT_ENABLE_N, O_INPUT_ACCEPT, O_CONFIG_COMPLETE_PIN;
  logic [3:0] w;
  int n_mismatch = 0;
  int checks_done = 0;
  // ----------------------------------------------------------------
  // Clock, block and host
  // ----------------------------------------------------------------
  always #5 I_CLK = ~I_CLK;
  assign w = {O_CONFIG_COMPLETE_PIN, O_GLOBAL_OUTPUT_ENABLE_N, O_GLOBAL_WRITE_BLOCK_N,
              O_CORE_GLOBAL_RESET_N};
  csw_top #(.FACTORY_STAMP(FSTAMP), .FACTORY_ID(FID)) dut (.*);
  csw_host host (.i_clk(I_CLK), .o_id_req(I_ID_READ_REQ), .o_rdbk_req(I_RDBK_REQ),
    .o_rdbk_tgt(I_RDBK_TARGET), .o_cmd_req(I_CMD_REQ), .o_cmd_tgt(I_CMD_TARGET),
    .o_cmd_op(I_CMD_OP), .i_id_valid(O_ID_VALID), .i_grant(O_RDBK_GRANT),
    .i_refuse(O_RDBK_REFUSE), .i_accept(O_CMD_ACCEPT), .i_reject(O_CMD_REJECT));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic step;
    @(posedge I_CLK);
    #1;
  endtask : step
  task automatic check(input string nm, input logic [63:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic rb(input logic [CMD_W-1:0] t, input logic g);
    logic sg, sr;
    host.rdbk(t, sg, sr);
    check("grant", sg, g);
    check("refuse", sr, !g);
  endtask : rb
  task automatic cm(input logic [CMD_W-1:0] t, op, input logic a);
    logic sa, sr;
    host.cmd(t, op, sa, sr);
    check("accept", sa, a);
    check("reject", sr, !a);
  endtask : cm
  task automatic do_reset;
    I_SYS_RST = 1'b1;
    I_LOAD_DONE = 1'b0;
    I_LOAD_ERROR = 1'b0;
    repeat (16) step();
    check("held controls", w, 4'h0);
    I_SYS_RST = 1'b0;
    step();
  endtask : do_reset
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  // Watchdog
  initial
  begin
    #200_000;
    n_mismatch++;
    conclude();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    int t[4];
    logic v;
    do_reset();
    for (int p = 0; p < NPORT; p++)
    begin
      I_CUSTOM_IDENTITY_ENABLE = p[0];
      I_USER_VERSION_VALID = p[0];
      I_STAMP_USER = 8'hA0 + 8'(p);
      host.read_id(p, v);
      check("id valid", v, 1'b1);
      check("id word", O_ID_WORD, p[0] ? I_OVERRIDE_IDENTITY_WORD : FID);
      check("die stamp", O_UNIQUE_DIE_STAMP, {I_STAMP_USER, FSTAMP});
      check("version", O_USER_VERSION_WORD, p[0] ? I_USER_VERSION_WORD : USER_VER_DEF);
    end
    $display("identity test ended");
    I_SRAM_READBACK_LOCK = 1'b1;
    rb(TGT_SRAM, 1'b0);
    rb(TGT_STORE, 1'b1);
    I_NONVOLATILE_READBACK_LOCK = 1'b1;
    step();
    I_NONVOLATILE_READBACK_LOCK = 1'b0;
    I_SRAM_READBACK_LOCK = 1'b0;
    rb(TGT_STORE, 1'b0);
    rb(TGT_SRAM, 1'b1);
    $display("readback test ended");
    I_SRAM_ERASE_PROGRAM_FUSE = 1'b1;
    cm(TGT_SRAM, CMD_ERASE, 1'b0);
    cm(TGT_SRAM, CMD_PROG, 1'b0);
    cm(TGT_STORE, CMD_ERASE, 1'b1);
    rb(TGT_STORE, 1'b1);
    cm(TGT_STORE, CMD_PROG, 1'b1);
    I_SRAM_ERASE_PROGRAM_FUSE = 1'b0;
    cm(TGT_SRAM, CMD_PROG, 1'b1);
    $display("command test ended");
    I_LOAD_ERROR = 1'b1;
    I_LOAD_DONE = 1'b1;
    repeat (20) step();
    check("error hold", {O_CORE_GLOBAL_RESET_N, O_CONFIG_COMPLETE_PIN}, 2'h0);
    check("error input", O_INPUT_ACCEPT, 1'b1);
    do_reset();
    I_LAST_IN_CHAIN = 1'b0;
    I_LOAD_DONE = 1'b1;
    repeat (20) step();
    check("not last", O_CORE_GLOBAL_RESET_N, 1'b0);
    I_LAST_IN_CHAIN = 1'b1;
    t = '{-1, -1, -1, -1};
    for (int i = 0; i < 30; i++)
    begin
      step();
      foreach (t[k]) if (t[k] < 0 && w[k] === 1'b1) t[k] = i;
    end
    check("wake start", t[0] inside {[0:4]}, 1'b1);
    check("wake order", t[0] < t[1] && t[1] < t[2] && t[2] < t[3], 1'b1);
    check("done pin", O_CONFIG_COMPLETE_PIN, 1'b1);
    $display("wake test ended");
    conclude();
  end
endmodule : csw_top_tb
